//--- rtl/rgmc_ctrl.v
// Summary of operation
// - After transmit ends, receive decoders are held in reset for the guard time.
// - Guard starts at end of transmitted EOF; receiver input ignored throughout.
// - Eight-bit guard code counts 9.44 us steps, codes 1 to 255.
// - Every protocol write reloads guard time with that standard's minimum response.
// - Presets: 9.44 us fast protocol, 66 us A and B, 293 us vicinity.
// - Guard register is 0x1F at reset and while chip enable is low.
// - Bits 5:4 pick clock output divider; 00 off, 01 divide by four.
// - System clock output is oscillator divided by 1, 2 or 4.
// - Divider code 10 gives half, code 11 the full oscillator rate.
// - Bits 2:0 select modulation depth, ASK 7 to 30 percent or OOK.
// - With bit 6 set, keying pin high forces OOK, low uses programmed depth.
// - Pin keying works only with bit 6 set in modulator and protocol registers.
// - In direct control the modulation signal is taken from the modulation pin.
// - Modulator register resets to 0x91; protocol writes reload all but divider.
`timescale 1ns/100ps
`include "rgmc_defs.vh"

module rgmc_ctrl #(
   parameter STEP_CYCLES = `RGMC_GUARD_STEP_CYC,
   parameter STEP_WIDTH  = 16
) (
   // Clock and reset
   input  wire       clk,
   input  wire       rst_n,
   // Chip enable, low presets the registers
   input  wire       chip_en,
   // Register port
   input  wire [7:0] reg_addr,
   input  wire [7:0] reg_wdata,
   input  wire       reg_wr,
   input  wire       reg_rd,
   output reg  [7:0] reg_rdata,
   // Transmitter side
   input  wire       tx_eof_done,
   input  wire       tx_mod,
   // Host pins
   input  wire       mod_pin,
   input  wire       ook_sel_pin,
   // Receiver control
   output reg        rx_decoder_hold,
   // Modulator control
   output reg        mod_out,
   output reg        ook_active,
   output reg  [2:0] depth_select,
   output reg        analog_keying_out,
   output reg        high_freq_crystal_enable,
   // Clock output to the host
   output reg        system_clock_output
);

   // Register file
   reg [7:0] protocol_reg;
   reg [7:0] protocol_next;
   reg [7:0] guard_time_reg;
   reg [7:0] guard_time_next;
   reg [7:0] mod_clock_reg;
   reg [7:0] mod_clock_next;

   // Guard timer state
   reg [7:0] guard_count_reg;
   reg [7:0] guard_count_next;
   reg       guard_active_reg;
   reg       guard_active_next;

   // Register port decode
   wire      wr_protocol;
   wire      wr_guard;
   wire      wr_mod;
   reg [7:0] rdata_next;

   // Derived controls
   reg [7:0] guard_preset;
   wire [1:0] prot_class;
   wire [1:0] clkdiv_code;
   wire [2:0] depth_code;
   wire       direct_ctrl;
   wire       step_tick;
   wire       clk_tick;
   reg  [2:0] clk_period;
   wire [7:0] status_word;

   // Writes only land while the chip is enabled
   assign wr_protocol = reg_wr && chip_en && (reg_addr == `RGMC_OFS_PROTOCOL);
   assign wr_guard    = reg_wr && chip_en && (reg_addr == `RGMC_OFS_GUARD_TIME);
   assign wr_mod      = reg_wr && chip_en && (reg_addr == `RGMC_OFS_MOD_CLOCK);

   // Fields of the stored registers
   assign prot_class  = protocol_reg[`RGMC_PROT_CLASS_MSB:`RGMC_PROT_CLASS_LSB];
   assign clkdiv_code = mod_clock_reg[`RGMC_MOD_CLKDIV_MSB:`RGMC_MOD_CLKDIV_LSB];
   assign depth_code  = mod_clock_reg[`RGMC_MOD_DEPTH_MSB:`RGMC_MOD_DEPTH_LSB];

   // Pin keying needs the enable in both registers
   assign direct_ctrl = mod_clock_reg[`RGMC_MOD_PIN_EN_BIT]
                        && protocol_reg[`RGMC_PROT_PIN_EN_BIT];

   // Preset guard time for the class being written
   always @* begin
      case (reg_wdata[`RGMC_PROT_CLASS_MSB:`RGMC_PROT_CLASS_LSB])
         `RGMC_CLASS_FAST: begin
            guard_preset = `RGMC_GUARD_FAST;
         end
         `RGMC_CLASS_PROX_A,
         `RGMC_CLASS_PROX_B: begin
            guard_preset = `RGMC_GUARD_PROX;
         end
         `RGMC_CLASS_VICINITY: begin
            guard_preset = `RGMC_GUARD_VICINITY;
         end
         default: begin
            guard_preset = `RGMC_GUARD_RESET;
         end
      endcase
   end

   // Next values of the protocol register
   always @* begin
      protocol_next = protocol_reg;
      if (!chip_en) begin
         protocol_next = `RGMC_PROTOCOL_RESET;
      end else if (wr_protocol) begin
         protocol_next = reg_wdata;
      end
   end

   // Guard register: protocol write wins over a direct write in the same cycle
   always @* begin
      guard_time_next = guard_time_reg;
      if (!chip_en) begin
         guard_time_next = `RGMC_GUARD_RESET;
      end else if (wr_protocol) begin
         guard_time_next = guard_preset;
      end else if (wr_guard) begin
         guard_time_next = reg_wdata;
      end
   end

   // Modulator register: protocol write keeps the divider bits
   always @* begin
      mod_clock_next = mod_clock_reg;
      if (!chip_en) begin
         mod_clock_next = `RGMC_MOD_RESET;
      end else if (wr_protocol) begin
         mod_clock_next = `RGMC_MOD_RESET;
         mod_clock_next[`RGMC_MOD_CLKDIV_MSB:`RGMC_MOD_CLKDIV_LSB] = clkdiv_code;
      end else if (wr_mod) begin
         mod_clock_next = reg_wdata;
      end
   end

   // Register file flip-flops
   always @(posedge clk) begin
      if (!rst_n) begin
         protocol_reg   <= `RGMC_PROTOCOL_RESET;
         guard_time_reg <= `RGMC_GUARD_RESET;
         mod_clock_reg  <= `RGMC_MOD_RESET;
      end else begin
         protocol_reg   <= protocol_next;
         guard_time_reg <= guard_time_next;
         mod_clock_reg  <= mod_clock_next;
      end
   end

   // Step timer, restarted on each end of frame so the first step is whole
   // A new end of frame inside a guard starts a fresh full interval
   rgmc_tick #(
      .WIDTH (STEP_WIDTH)
   ) u_step_tick (
      .clk     (clk),
      .rst_n   (rst_n),
      .restart (tx_eof_done),
      .enable  (guard_active_reg),
      .period  (STEP_CYCLES[STEP_WIDTH-1:0]),
      .tick    (step_tick)
   );

   // Guard timer: code times steps after the end of frame
   // Whole steps only; the hold may outlast the exact time by one cycle
   always @* begin
      guard_count_next  = guard_count_reg;
      guard_active_next = guard_active_reg;
      if (!chip_en) begin
         guard_count_next  = 8'h00;
         guard_active_next = 1'b0;
      end else if (tx_eof_done) begin
         // Code 0 means no guard at all
         guard_count_next  = guard_time_reg;
         guard_active_next = (guard_time_reg != 8'h00);
      end else if (guard_active_reg && step_tick) begin
         guard_count_next = guard_count_reg - 8'h01;
         if (guard_count_reg == 8'h01) begin
            guard_active_next = 1'b0;
         end
      end
   end

   // Guard timer flip-flops
   always @(posedge clk) begin
      if (!rst_n) begin
         guard_count_reg  <= 8'h00;
         guard_active_reg <= 1'b0;
      end else begin
         guard_count_reg  <= guard_count_next;
         guard_active_reg <= guard_active_next;
      end
   end

   // Hold the decoders and mask receiver input while the guard runs
   always @(posedge clk) begin
      if (!rst_n) begin
         rx_decoder_hold <= 1'b0;
      end else begin
         rx_decoder_hold <= guard_active_next;
      end
   end

   // Half-periods of the clock output in units of clk
   always @* begin
      case (clkdiv_code)
         `RGMC_CLKDIV_FULL: begin
            clk_period = 3'h1;
         end
         `RGMC_CLKDIV_HALF: begin
            clk_period = 3'h2;
         end
         `RGMC_CLKDIV_QUARTER: begin
            clk_period = 3'h4;
         end
         default: begin
            clk_period = 3'h0;
         end
      endcase
   end

   // Toggle pace for the clock output, idle when the output is off
   rgmc_tick #(
      .WIDTH (3)
   ) u_clk_tick (
      .clk     (clk),
      .rst_n   (rst_n),
      .restart (1'b0),
      .enable  (clkdiv_code != `RGMC_CLKDIV_OFF),
      .period  (clk_period),
      .tick    (clk_tick)
   );

   // Clock output; the oscillator rate is modelled as clk over two
   // Changing the divider mid-period may give one short half-period
   always @(posedge clk) begin
      if (!rst_n) begin
         system_clock_output <= 1'b0;
      end else if (clkdiv_code == `RGMC_CLKDIV_OFF) begin
         system_clock_output <= 1'b0;
      end else if (clk_tick) begin
         system_clock_output <= !system_clock_output;
      end
   end

   // Modulation source; the host pin only counts in direct control
   always @(posedge clk) begin
      if (!rst_n) begin
         mod_out <= 1'b0;
      end else if (direct_ctrl) begin
         mod_out <= mod_pin;
      end else begin
         mod_out <= tx_mod;
      end
   end

   // Keying choice; the pin can force full keying but never cancel it
   always @(posedge clk) begin
      if (!rst_n) begin
         ook_active <= 1'b1;
      end else if (direct_ctrl) begin
         ook_active <= ook_sel_pin || (depth_code == `RGMC_DEPTH_OOK);
      end else begin
         ook_active <= (depth_code == `RGMC_DEPTH_OOK);
      end
   end

   // Depth code copied out for the modulator
   always @(posedge clk) begin
      if (!rst_n) begin
         depth_select <= `RGMC_DEPTH_OOK;
      end else begin
         depth_select <= depth_code;
      end
   end

   // Analog keying bit; taken from the next value to save a cycle
   always @(posedge clk) begin
      if (!rst_n) begin
         analog_keying_out <= 1'b0;
      end else begin
         analog_keying_out <= mod_clock_next[`RGMC_MOD_ANALOG_BIT];
      end
   end

   // Crystal enable; set again by every protocol reload
   always @(posedge clk) begin
      if (!rst_n) begin
         high_freq_crystal_enable <= 1'b1;
      end else begin
         high_freq_crystal_enable <= mod_clock_next[`RGMC_MOD_XTAL_BIT];
      end
   end

   // Status word shows live block state
   assign status_word = {4'h0, direct_ctrl, ook_active, system_clock_output,
                         guard_active_reg};

   // Read mux, unmapped addresses read zero
   always @* begin
      case (reg_addr)
         `RGMC_OFS_PROTOCOL: begin
            rdata_next = protocol_reg;
         end
         `RGMC_OFS_GUARD_TIME: begin
            rdata_next = guard_time_reg;
         end
         `RGMC_OFS_MOD_CLOCK: begin
            rdata_next = mod_clock_reg;
         end
         `RGMC_OFS_STATUS: begin
            rdata_next = status_word;
         end
         default: begin
            rdata_next = 8'h00;
         end
      endcase
   end

   // Read data valid only in the cycle after the strobe
   always @(posedge clk) begin
      if (!rst_n) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         reg_rdata <= rdata_next;
      end else begin
         reg_rdata <= 8'h00;
      end
   end

endmodule

//--- rtl/rgmc_defs.vh
`ifndef RGMC_DEFS_VH
`define RGMC_DEFS_VH

// Register offsets on the plain register port
`define RGMC_OFS_PROTOCOL      8'h01
`define RGMC_OFS_GUARD_TIME    8'h08
`define RGMC_OFS_MOD_CLOCK     8'h09
`define RGMC_OFS_STATUS        8'h20

// Reset and preset values
`define RGMC_GUARD_RESET       8'h1f
`define RGMC_MOD_RESET         8'h91
`define RGMC_PROTOCOL_RESET    8'h00

// Modulator register field positions
`define RGMC_MOD_DEPTH_LSB     0
`define RGMC_MOD_DEPTH_MSB     2
`define RGMC_MOD_ANALOG_BIT    3
`define RGMC_MOD_CLKDIV_LSB    4
`define RGMC_MOD_CLKDIV_MSB    5
`define RGMC_MOD_PIN_EN_BIT    6
`define RGMC_MOD_XTAL_BIT      7

// Protocol register fields
`define RGMC_PROT_PIN_EN_BIT   6
`define RGMC_PROT_CLASS_LSB    0
`define RGMC_PROT_CLASS_MSB    1

// Protocol classes held in the class field
`define RGMC_CLASS_VICINITY    2'h0
`define RGMC_CLASS_PROX_A      2'h1
`define RGMC_CLASS_PROX_B      2'h2
`define RGMC_CLASS_FAST        2'h3

// Guard presets per class, in 9.44 us steps (9.44, 66, 293 us)
`define RGMC_GUARD_FAST        8'h01
`define RGMC_GUARD_PROX        8'h07
`define RGMC_GUARD_VICINITY    8'h1f

// Depth and clock divider codes
`define RGMC_DEPTH_OOK         3'h1
`define RGMC_CLKDIV_OFF        2'h0
`define RGMC_CLKDIV_QUARTER    2'h1
`define RGMC_CLKDIV_HALF       2'h2
`define RGMC_CLKDIV_FULL       2'h3

// Timing: guard step in ns and clock period in ns
`define RGMC_GUARD_STEP_NS     9440
`define RGMC_CLK_PERIOD_NS     10
`define RGMC_GUARD_STEP_CYC    (`RGMC_GUARD_STEP_NS / `RGMC_CLK_PERIOD_NS)

`endif

//--- rtl/rgmc_tick.v
`timescale 1ns/100ps

// Free counter giving a one-cycle tick every period cycles
module rgmc_tick #(
   parameter WIDTH = 10
) (
   // Clock and reset
   input  wire             clk,
   input  wire             rst_n,
   // Control
   input  wire             restart,
   input  wire             enable,
   input  wire [WIDTH-1:0] period,
   // Tick out
   output reg              tick
);

   reg [WIDTH-1:0] count_reg;
   reg [WIDTH-1:0] count_next;
   reg             wrap;

   // Wrap when the last cycle of the period is reached
   always @* begin
      wrap       = (count_reg >= period - {{(WIDTH-1){1'b0}}, 1'b1});
      count_next = count_reg + {{(WIDTH-1){1'b0}}, 1'b1};
      if (restart || !enable || wrap) begin
         count_next = {WIDTH{1'b0}};
      end
   end

   // Restart keeps the phase aligned to the triggering event
   always @(posedge clk) begin
      if (!rst_n) begin
         count_reg <= {WIDTH{1'b0}};
         tick      <= 1'b0;
      end else begin
         count_reg <= count_next;
         tick      <= enable && !restart && wrap;
      end
   end

endmodule

//--- tb/rgmc_checker.sv
`timescale 1ns/100ps
// Watches the block's ports against shadow copies of its registers
module rgmc_checker (
   // Clock and reset
   input logic       clk,
   input logic       rst_n,
   input logic       chip_en,
   // Register port
   input logic [7:0] reg_addr,
   input logic [7:0] reg_wdata,
   input logic       reg_wr,
   input logic       reg_rd,
   input logic [7:0] reg_rdata,
   // Pins and outputs
   input logic       tx_eof_done,
   input logic       tx_mod,
   input logic       mod_pin,
   input logic       ook_sel_pin,
   input logic       rx_decoder_hold,
   input logic       mod_out,
   input logic       ook_active,
   input logic       system_clock_output
);
   logic [7:0] g_sh;
   logic [7:0] m_sh;
   logic       p6_sh;
   wire        dir = m_sh[6] & p6_sh;
   wire        msel = dir ? mod_pin : tx_mod;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // Shadow registers; chip enable low presets like reset
   always @(posedge clk) begin
      if (!rst_n || !chip_en) begin
         g_sh <= 8'h1f;
         m_sh <= 8'h91;
         p6_sh <= 1'b0;
      end else if (reg_wr && reg_addr == 8'h08) begin
         g_sh <= reg_wdata;
      end else if (reg_wr && reg_addr == 8'h09) begin
         m_sh <= reg_wdata;
      end else if (reg_wr && reg_addr == 8'h01) begin
         p6_sh <= reg_wdata[6];
         m_sh <= {2'h2, m_sh[5:4], 4'h1};
         g_sh <= (reg_wdata[1:0] == 2'h3) ? 8'h01 : (reg_wdata[1:0] == 2'h0) ? 8'h1f : 8'h07;
      end
   end
   AST_HOLD_CAUSE: assert property ($rose(rx_decoder_hold) |-> $past(tx_eof_done))
      else $error("guard started without end of frame");
   AST_HOLD_MIN: assert property ($rose(rx_decoder_hold) && chip_en |=> rx_decoder_hold)
      else $error("guard shorter than one step");
   AST_HOLD_CE: assert property (!chip_en |=> !rx_decoder_hold)
      else $error("guard kept with chip disabled");
   AST_GUARD_READ: assert property (reg_rd && reg_addr == 8'h08 |=> reg_rdata == $past(g_sh))
      else $error("guard register readback wrong");
   AST_MOD_READ: assert property (reg_rd && reg_addr == 8'h09 |=> reg_rdata == $past(m_sh))
      else $error("modulator register readback wrong");
   AST_MOD_SRC: assert property (1'b1 |=> mod_out == $past(msel))
      else $error("modulation source wrong");
   AST_OOK_PIN: assert property (dir && ook_sel_pin |=> ook_active)
      else $error("keying pin did not force full keying");
   AST_CLK_OFF: assert property ((m_sh[5:4] == 2'h0)[*3] |-> !system_clock_output)
      else $error("clock output not stopped");
   AST_CLK_FULL: assert property ((m_sh[5:4] == 2'h3)[*3] |-> $changed(system_clock_output))
      else $error("full rate clock not toggling");
   AST_CLK_QTR: assert property ((m_sh[5:4] == 2'h1)[*8] ##0 $changed(system_clock_output)
      |=> ($stable(system_clock_output) || m_sh[5:4] != 2'h1)[*3])
      else $error("quarter rate clock toggles early");
endmodule

bind rgmc_ctrl rgmc_checker chk_i (.clk, .rst_n, .chip_en, .reg_addr, .reg_wdata, .reg_wr,
   .reg_rd, .reg_rdata, .tx_eof_done, .tx_mod, .mod_pin, .ook_sel_pin, .rx_decoder_hold,
   .mod_out, .ook_active, .system_clock_output);

//--- tb/rgmc_ctrl_bench.sv
`timescale 1ns/100ps
module rgmc_ctrl_bench;
   logic       clk, rst_n, chip_en, reg_wr, reg_rd, tx_eof_done, tx_mod, keying_en, ook_req;
   logic [7:0] reg_addr, reg_wdata, reg_rdata;
   logic       rx_decoder_hold, mod_out, ook_active, analog_keying_out, high_freq_crystal_enable;
   logic       system_clock_output, mod_pin, ook_sel_pin;
   logic [2:0] depth_select;
   int         edges, fails = 0, n_compared = 0;

   // Short guard step keeps the longest guard near a thousand cycles
   rgmc_ctrl #(.STEP_CYCLES(4)) uut (.clk, .rst_n, .chip_en, .reg_addr, .reg_wdata, .reg_wr,
      .reg_rd, .reg_rdata, .tx_eof_done, .tx_mod, .mod_pin, .ook_sel_pin, .rx_decoder_hold,
      .mod_out, .ook_active, .depth_select, .analog_keying_out, .high_freq_crystal_enable,
      .system_clock_output);
   rgmc_host host (.clk, .keying_en, .ook_req, .system_clock_output, .mod_pin, .ook_sel_pin,
      .edges);

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic conclude;
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   // Bus cycles; each leaves an idle cycle so strobes never double-assign
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      @(posedge clk);
   endtask

   task automatic rdc(input logic [7:0] a, input logic [7:0] e);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, e);
      @(posedge clk);
   endtask

   // Measures hold length in cycles after one end of frame
   task automatic guard(input logic [7:0] code);
      int n;
      n = 0;
      wr(8'h08, code);
      tx_eof_done <= 1'b1;
      @(posedge clk);
      tx_eof_done <= 1'b0;
      while (n < 1100) begin
         #1;
         if (rx_decoder_hold !== 1'b1) break;
         n++;
         @(posedge clk);
      end
      if (n == 1100) begin
         fails++;
         conclude();
      end
      chk(16'(n + 1 >= code * 4 && n <= code * 4 + 1), 16'h1);
      @(posedge clk);
   endtask

   task automatic t_reset;
      rdc(8'h08, 8'h1f);
      rdc(8'h09, 8'h91);
      rdc(8'h3c, 8'h00);
      chk(high_freq_crystal_enable, 1'b1);
   endtask

   task automatic t_guard;
      guard(8'h00);
      guard(8'h01);
      guard(8'h03);
      guard(8'hff);
   endtask

   // Every class presets the guard; divider bits survive the reload
   task automatic t_preset;
      logic [7:0] pre [4] = '{8'h1f, 8'h07, 8'h07, 8'h01};
      for (int c = 0; c < 4; c++) begin
         wr(8'h09, 8'h7a);
         #1 chk(analog_keying_out, 1'b1);
         chk(high_freq_crystal_enable, 1'b0);
         wr(8'h08, 8'h55);
         wr(8'h01, 8'(c));
         rdc(8'h08, pre[c]);
         rdc(8'h09, 8'hb1);
      end
      chk(depth_select, 3'h1);
      chk(ook_active, 1'b1);
      chk(analog_keying_out, 1'b0);
      chk(high_freq_crystal_enable, 1'b1);
   endtask

   task automatic t_chip;
      wr(8'h09, 8'h22);
      wr(8'h08, 8'h09);
      tx_eof_done <= 1'b1;
      @(posedge clk);
      tx_eof_done <= 1'b0;
      chip_en <= 1'b0;
      wr(8'h08, 8'h44);
      #1 chk(rx_decoder_hold, 1'b0);
      @(posedge clk);
      chip_en <= 1'b1;
      @(posedge clk);
      rdc(8'h08, 8'h1f);
      rdc(8'h09, 8'h91);
   endtask

   task automatic t_clock;
      int e;
      for (int c = 0; c < 4; c++) begin
         wr(8'h09, {2'h2, 2'(c), 4'h1});
         repeat (16) @(posedge clk);
         e = edges;
         repeat (64) @(posedge clk);
         chk(16'(edges - e), c == 0 ? 16'h0 : 16'(64 >> (4 - c)));
      end
   endtask

   // Direct keying on, then off with only the modulator bit set
   task automatic t_direct;
      logic p, o;
      for (int d = 1; d >= 0; d--) begin
         wr(8'h01, {1'b0, d[0], 6'h0});
         wr(8'h09, 8'h42);
         keying_en <= 1'b1;
         for (int i = 0; i < 8; i++) begin
            ook_req <= ~i[1];
            tx_mod <= i[0];
            @(posedge clk);
            #1 p = d ? mod_pin : tx_mod;
            o = d ? ook_sel_pin : 1'b0;
            @(posedge clk);
            #1 chk(mod_out, p);
            chk(ook_active, o);
            @(posedge clk);
         end
         chk(depth_select, 3'h2);
      end
   endtask

   initial begin
      rst_n = 1'b0;
      chip_en = 1'b1;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      tx_eof_done = 1'b0;
      tx_mod = 1'b0;
      keying_en = 1'b0;
      ook_req = 1'b0;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      t_reset();
      t_guard();
      t_preset();
      t_chip();
      t_clock();
      t_direct();
      conclude();
   end
endmodule

//--- tb/rgmc_host.sv
`timescale 1ns/100ps
// Host side: drives the keying pins, counts clock output edges
module rgmc_host (
   // Clock and bench control
   input  logic clk,
   input  logic keying_en,
   input  logic ook_req,
   // Pins
   input  logic system_clock_output,
   output logic mod_pin,
   output logic ook_sel_pin,
   output int   edges
);
   logic [3:0] pat_reg = 4'h0;
   logic       sck_reg = 1'b0;
   initial begin
      mod_pin = 1'b0;
      ook_sel_pin = 1'b0;
      edges = 0;
   end
   // Idle pins wander every cycle so a stale level is never mistaken for data
   always @(posedge clk) begin
      pat_reg <= pat_reg + 4'h1;
      sck_reg <= system_clock_output;
      if (system_clock_output && !sck_reg) edges <= edges + 1;
      if (keying_en) begin
         mod_pin <= pat_reg[1];
         ook_sel_pin <= ook_req;
      end else begin
         mod_pin <= ~mod_pin;
         ook_sel_pin <= ~ook_sel_pin;
      end
   end
endmodule
